// ### logic/rd_pkg.sv
// constants shared by the character route decoder and its column decoder
// assumes one 10 MHz clock and a synchronous active-high clear
package rd_pkg;
   localparam int CHAR_W = 6;
   localparam int LOW_W = 4;
   localparam int ZONE_W = 2;
   localparam int ZONE_LSB = 4;
   localparam int NUM_COLS = 10;
   localparam int NUM_GROUPS = 4;
   localparam int NUM_ROUTES = 40;
   // usable excess-three window of the low bits
   localparam logic [LOW_W-1:0] XS3_MIN = 4'h3;
   localparam logic [LOW_W-1:0] XS3_MAX = 4'hC;
   // cleared register holds a code outside the usable window
   localparam logic [CHAR_W-1:0] CLEAR_CHAR = 6'h00;
   localparam logic [NUM_COLS-1:0] PULSE_NONE = 10'h000;
   localparam logic [NUM_COLS-1:0] PULSE_ONE = 10'h001;
   localparam logic [NUM_ROUTES-1:0] ROUTE_NONE = 40'h00_0000_0000;
   localparam logic [NUM_ROUTES-1:0] ROUTE_ONE = 40'h00_0000_0001;
   localparam logic [NUM_GROUPS-1:0] GROUP_NONE = 4'h0;
   localparam logic [NUM_GROUPS-1:0] GROUP_FIRST = 4'h1;
   localparam logic [NUM_GROUPS-1:0] GROUP_LAST = 4'h8;
   localparam logic [ZONE_W-1:0] ZONE_LAST = 2'h3;

   // held state of the decoder
   typedef struct packed {
      logic [CHAR_W-1:0] char_ff;
      logic [NUM_COLS-1:0] pulse_ff;
   } rd_state_s;
endpackage : rd_pkg

// ### logic/rd_col_if.sv
// carrier between the decoder top and its column decoder
// assumes both ends sit in the same clock domain
`timescale 1ns/100ps
interface rd_col_if;
   import rd_pkg::*;
   logic [CHAR_W-1:0] held_char;
   logic usable;
   logic [LOW_W-1:0] col;
   logic [ZONE_W-1:0] zone;
   modport dec (input held_char, output usable, output col, output zone);
   modport user (output held_char, input usable, input col, input zone);
endinterface : rd_col_if

// ### logic/rd_col_decode.sv
// column decoder: splits a held character into zone and column
// assumes the character is already registered by the caller
`timescale 1ns/100ps
module rd_col_decode (
   rd_col_if.dec bus
);
   import rd_pkg::*;
   logic [LOW_W-1:0] low_bits;

   // only the low excess-three bits choose the column
   always_comb begin
      low_bits = bus.held_char[LOW_W-1:0];
      bus.usable = (low_bits >= XS3_MIN) && (low_bits <= XS3_MAX);
      bus.col = low_bits - XS3_MIN; // column 0 sits at excess-three three
      bus.zone = bus.held_char[ZONE_LSB +: ZONE_W];
   end
endmodule : rd_col_decode

// ### logic/rd_route_decoder.sv
// character route decoder: holding register plus pulse, group and full routes
// assumes the step sequencer loads a character before it drives any probe
//
// Behaviour
// - holds one six-bit character, forty usable codes
// - pulse probe emits one pulse on one output
// - pulse route uses only the low bits
// - group probe enables exactly one group output
// - group column follows low bits, zone ignored
// - each group owns its own ten outputs
// - full probe enables the exact character's output
// - full route compares all six character bits
// - unusable character enables no full route
// - one held character serves many probes
`timescale 1ns/100ps
module rd_route_decoder (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic load_in,
   input wire logic [rd_pkg::CHAR_W-1:0] char_in,
   input wire logic pulse_route_probe_in,
   input wire logic [rd_pkg::NUM_GROUPS-1:0] group_level_probe_in,
   input wire logic full_level_probe_in,
   output logic [rd_pkg::NUM_COLS-1:0] pulse_route_output_out,
   output logic [rd_pkg::NUM_ROUTES-1:0] level_route_output_out,
   output logic [rd_pkg::CHAR_W-1:0] route_char_out
);
   import rd_pkg::*;

   rd_state_s st_ff;
   rd_state_s nxt_st;
   rd_col_if col_bus ();

   // column and zone come from the held character only
   rd_col_decode u_col_decode (
      .bus(col_bus.dec)
   );
   assign col_bus.held_char = st_ff.char_ff;

   // next state: load, one-cycle pulse, synchronous clear
   always_comb begin
      nxt_st = st_ff;
      nxt_st.pulse_ff = PULSE_NONE; // pulse lives one cycle only
      if (load_in) begin
         nxt_st.char_ff = char_in;
      end
      // probe reads the held character, so a same-cycle load is seen next time
      if (pulse_route_probe_in && col_bus.usable) begin
         nxt_st.pulse_ff[col_bus.col] = 1'b1;
      end
      if (rst_in) begin
         nxt_st.char_ff = CLEAR_CHAR;
         nxt_st.pulse_ff = PULSE_NONE;
      end
   end

   // the whole state registers in one place
   always_ff @(posedge clk_in) begin
      st_ff <= nxt_st;
   end

   // level routes: combinational so they track the probe levels
   always_comb begin
      int idx;
      idx = 0;
      level_route_output_out = ROUTE_NONE;
      if (col_bus.usable) begin
         // each asserted group probe enables the matching column in its row
         for (int g = 0; g < NUM_GROUPS; g++) begin
            if (group_level_probe_in[g]) begin
               idx = g * NUM_COLS + int'(col_bus.col);
               level_route_output_out[idx] = 1'b1;
            end
         end
         // zone and column together name exactly one of forty routes
         if (full_level_probe_in) begin
            idx = int'(col_bus.zone) * NUM_COLS + int'(col_bus.col);
            level_route_output_out[idx] = 1'b1;
         end
      end
      // an unusable character leaves every level route off
   end

   // character is never altered by probing, only by load or clear
   assign pulse_route_output_out = st_ff.pulse_ff;
   assign route_char_out = st_ff.char_ff;

   // checks below watch only what this module drives
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   logic [NUM_ROUTES-1:0] full_expect;
   logic [NUM_ROUTES-1:0] last_group_expect;
   always_comb begin
      full_expect = ROUTE_ONE << (int'(col_bus.zone) * NUM_COLS + int'(col_bus.col));
      last_group_expect = ROUTE_ONE << (int'(ZONE_LAST) * NUM_COLS + int'(col_bus.col));
   end

   // holding register: a load lands unless a clear shares its edge
   a_char_load_taken: assert property (
      load_in && !rst_in |=> route_char_out == $past(char_in))
      else $error("loaded character not held");

   a_char_held_stable: assert property (
      !load_in && !rst_in |=> $stable(route_char_out))
      else $error("held character changed without a load");

   // the clear itself is checked, so the default disable must not mask it
   a_clear_unusable: assert property (@(posedge clk_in) disable iff (1'b0)
      rst_in |=> (route_char_out == CLEAR_CHAR) && (pulse_route_output_out == PULSE_NONE))
      else $error("clear did not empty the holding register");

   a_pulse_one_route: assert property (
      $onehot0(pulse_route_output_out))
      else $error("more than one pulse route active");

   // pulse route: one cycle after the probe, column from the low bits only
   a_pulse_after_probe: assert property (
      (pulse_route_probe_in && col_bus.usable && !rst_in)
      |=> pulse_route_output_out == (PULSE_ONE << $past(col_bus.col)))
      else $error("pulse on wrong route or missing");

   a_pulse_single_cycle: assert property (
      !(pulse_route_probe_in && col_bus.usable) |=> pulse_route_output_out == PULSE_NONE)
      else $error("pulse without a probe or too long");

   // group rows at both ends of the table
   a_group_first_row: assert property (
      (group_level_probe_in == GROUP_FIRST) && !full_level_probe_in && col_bus.usable
      |-> level_route_output_out == (ROUTE_ONE << col_bus.col))
      else $error("group one route wrong");

   a_group_last_row: assert property (
      (group_level_probe_in == GROUP_LAST) && !full_level_probe_in && col_bus.usable
      |-> level_route_output_out == last_group_expect)
      else $error("group four route wrong");

   a_full_exact_route: assert property (
      full_level_probe_in && (group_level_probe_in == GROUP_NONE) && col_bus.usable
      |-> level_route_output_out == full_expect)
      else $error("full route not the held character");

   // a new zone under a held full probe must move the route
   a_full_zone_sense: assert property (
      full_level_probe_in && (group_level_probe_in == GROUP_NONE) && col_bus.usable
      ##1 full_level_probe_in && (group_level_probe_in == GROUP_NONE) && col_bus.usable
      && $changed(col_bus.zone) |-> !$stable(level_route_output_out))
      else $error("zone bits ignored by full route");

   // refused characters and idle probes leave every level route off
   a_unusable_silent: assert property (
      !col_bus.usable |-> level_route_output_out == ROUTE_NONE)
      else $error("route enabled by unusable character");

   a_no_probe_quiet: assert property (
      (group_level_probe_in == GROUP_NONE) && !full_level_probe_in
      |-> level_route_output_out == ROUTE_NONE)
      else $error("level route without a probe");

   // refused characters never pulse, whatever the probe does
   a_pulse_unusable_none: assert property (
      !col_bus.usable |=> pulse_route_output_out == PULSE_NONE)
      else $error("pulse from an unusable character");

   // a clear also silences every level route, probes or not
   a_clear_level_quiet: assert property (@(posedge clk_in) disable iff (1'b0)
      rst_in |=> level_route_output_out == ROUTE_NONE)
      else $error("level route enabled right after a clear");

   // column decoder must agree with the held character
   a_col_window: assert property (
      col_bus.usable == ((route_char_out[LOW_W-1:0] >= XS3_MIN)
      && (route_char_out[LOW_W-1:0] <= XS3_MAX)))
      else $error("usable flag disagrees with the held character");

   // a usable column stays inside one row, zone straight from the upper bits
   a_col_in_range: assert property (
      col_bus.usable |-> (col_bus.col < NUM_COLS)
      && (col_bus.zone == route_char_out[ZONE_LSB +: ZONE_W]))
      else $error("column or zone out of range");

   // full route stays on whatever group probes join it
   a_full_with_groups: assert property (
      full_level_probe_in && col_bus.usable
      |-> (level_route_output_out & full_expect) == full_expect)
      else $error("full route lost beside a group probe");

   // each probe adds at most its own route, never a stray one
   a_level_count_bound: assert property (
      $countones(level_route_output_out)
      <= $countones(group_level_probe_in) + int'(full_level_probe_in))
      else $error("more level routes than probes");

   // per group: one route in its own row while probed, none when neither its probe nor the full probe's zone selects it
   for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_row_chk
      a_group_row_one: assert property (@(posedge clk_in) disable iff (rst_in)
         group_level_probe_in[g] && col_bus.usable
         |-> $onehot(level_route_output_out[g*NUM_COLS +: NUM_COLS]))
         else $error("probed group row not one-hot");

      a_group_row_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
         !group_level_probe_in[g] && !(full_level_probe_in && (int'(col_bus.zone) == g))
         |-> ~|level_route_output_out[g*NUM_COLS +: NUM_COLS])
         else $error("unprobed group row enabled");
   end

   // main scenarios the bench is expected to reach
   c_full_zone_step: cover property (
      full_level_probe_in && col_bus.usable
      ##1 full_level_probe_in && col_bus.usable && $changed(col_bus.zone));
   c_pulse_route: cover property (
      load_in ##1 pulse_route_probe_in && col_bus.usable ##1 |pulse_route_output_out);
   c_group_route: cover property (
      col_bus.usable && (group_level_probe_in == GROUP_LAST));
   c_full_route: cover property (
      col_bus.usable && full_level_probe_in);
   c_shared_char: cover property (
      col_bus.usable && group_level_probe_in[0] ##1 !load_in && group_level_probe_in[3]);
endmodule : rd_route_decoder

// ### verif/rd_step_seq.sv
// step sequencer model: loads the route character, then drives probes
// assumes the bench calls drive once per clock cycle
`timescale 1ns/100ps
module rd_step_seq (
   input wire logic clk_in,
   output logic load_out,
   output logic [rd_pkg::CHAR_W-1:0] char_out,
   output logic pulse_out,
   output logic [rd_pkg::NUM_GROUPS-1:0] group_out,
   output logic full_out
);
   import rd_pkg::*;
   // idle until the first step
   initial begin
      load_out = 1'b0;
      char_out = CLEAR_CHAR;
      pulse_out = 1'b0;
      group_out = GROUP_NONE;
      full_out = 1'b0;
   end
   // one program step per edge; callers load before probing
   task automatic drive(input logic l, input logic [CHAR_W-1:0] c, input logic p,
      input logic [NUM_GROUPS-1:0] g, input logic f);
      @(posedge clk_in);
      load_out <= l;
      char_out <= c;
      pulse_out <= p;
      group_out <= g;
      full_out <= f;
   endtask : drive
endmodule : rd_step_seq

// ### verif/rd_route_decoder_tb_top.sv
// bench for the route decoder: expected outputs queued per cycle
// assumes the step sequencer model drives every decoder input except the clock and the clear, which the bench drives itself
`timescale 1ns/100ps
module rd_route_decoder_tb_top;
   import rd_pkg::*;
   logic clk_in, rst_in, ld, pp, fp;
   logic [CHAR_W-1:0] ch, held, char_o;
   logic [NUM_GROUPS-1:0] gp;
   logic [NUM_COLS-1:0] pend, pls_o;
   logic [NUM_ROUTES-1:0] lvl_o;
   logic [55:0] exp_q[$];
   logic [55:0] e;
   int err_count, num_checks;
   rd_step_seq seq (.clk_in(clk_in), .load_out(ld), .char_out(ch), .pulse_out(pp),
      .group_out(gp), .full_out(fp));
   rd_route_decoder uut (.clk_in(clk_in), .rst_in(rst_in), .load_in(ld), .char_in(ch),
      .pulse_route_probe_in(pp), .group_level_probe_in(gp), .full_level_probe_in(fp),
      .pulse_route_output_out(pls_o), .level_route_output_out(lvl_o), .route_char_out(char_o));
   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // routes expected from the held code; unusable codes route nothing
   function automatic logic [NUM_ROUTES-1:0] routes(input logic [CHAR_W-1:0] c,
      input logic [NUM_GROUPS-1:0] g, input logic f);
      logic [NUM_ROUTES-1:0] r;
      r = ROUTE_NONE;
      if (c[3:0] >= XS3_MIN && c[3:0] <= XS3_MAX) begin
         for (int i = 0; i < NUM_GROUPS; i++)
            if (g[i])
               r[i * NUM_COLS + int'(c[3:0]) - int'(XS3_MIN)] = 1'b1;
         if (f)
            r[int'(c[5:4]) * NUM_COLS + int'(c[3:0]) - int'(XS3_MIN)] = 1'b1;
      end
      return r;
   endfunction : routes
   task automatic check(input string nm, input logic [NUM_ROUTES-1:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      if (err_count == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : complete_run
   // one cycle of stimulus plus the outputs it must show
   task automatic step(input logic r, l, input logic [CHAR_W-1:0] c, input logic p,
      input logic [NUM_GROUPS-1:0] g, input logic f);
      seq.drive(l, c, p, g, f);
      rst_in <= r;
      exp_q.push_back({held, pend, routes(held, g, f)});
      pend = PULSE_NONE;
      if (p && held[3:0] >= XS3_MIN && held[3:0] <= XS3_MAX)
         pend = PULSE_ONE << (held[3:0] - XS3_MIN);
      if (l)
         held = c;
      if (r) begin
         held = CLEAR_CHAR;
         pend = PULSE_NONE;
      end
   endtask : step
   // monitor: outputs are settled by the falling edge
   always @(negedge clk_in) begin
      if (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check("route_char", NUM_ROUTES'(char_o), NUM_ROUTES'(e[55:50]));
         check("pulse_route", NUM_ROUTES'(pls_o), NUM_ROUTES'(e[49:40]));
         check("level_route", lvl_o, e[39:0]);
      end
   end
   initial begin
      #200us;
      err_count++;
      complete_run();
   end
   initial begin
      err_count = 0;
      num_checks = 0;
      void'($urandom(26));
      rst_in = 1'b1;
      held = CLEAR_CHAR;
      pend = PULSE_NONE;
      repeat (16) @(posedge clk_in);
      // every code, then back-to-back probes on all routes
      for (int i = 0; i < 64; i++) begin
         step(1'b0, 1'b1, 6'(i), 1'b0, GROUP_NONE, 1'b0);
         step(1'b0, 1'b0, CLEAR_CHAR, 1'b1, 4'hF, 1'b1);
         step(1'b0, 1'b0, CLEAR_CHAR, 1'b1, 4'($urandom), 1'b0);
      end
      // full and pulse probes held while every usable code is loaded, zone moving each step
      for (int i = 0; i < NUM_ROUTES; i++)
         step(1'b0, 1'b1, {2'(i % NUM_GROUPS), 4'(int'(XS3_MIN) + i / NUM_GROUPS)}, 1'b1,
            GROUP_NONE, 1'b1);
      // clear in mid-run, then probes must route nothing
      step(1'b1, 1'b1, 6'h05, 1'b1, 4'hF, 1'b1);
      step(1'b0, 1'b0, 6'h05, 1'b1, 4'hF, 1'b1);
      // random steps: same-cycle load and probe, rare clears
      repeat (300)
         step(($urandom % 60) == 0, ($urandom % 4) == 0, 6'($urandom), 1'($urandom),
            4'($urandom), 1'($urandom));
      step(1'b0, 1'b0, CLEAR_CHAR, 1'b0, GROUP_NONE, 1'b0);
      repeat (2) @(posedge clk_in);
      complete_run();
   end
endmodule : rd_route_decoder_tb_top
